/* File: rim_pkg.sv */
package rim_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RIM_OFS_IRQ_SEL = 8'h0D;
  localparam logic [7:0] RIM_OFS_FILL_TX = 8'h0E;
  localparam logic [7:0] RIM_OFS_SL_LIMIT = 8'h0F;

  // ----------------------------------------------------------------
  // Field positions, interrupt_config_group offset 0x0D
  // ----------------------------------------------------------------
  localparam int RIM_B_RX_IRQ0_HI = 7;
  localparam int RIM_B_RX_IRQ0_LO = 6;
  localparam int RIM_B_RX_IRQ1_HI = 5;
  localparam int RIM_B_RX_IRQ1_LO = 4;
  localparam int RIM_B_TX_IRQ1 = 3;
  localparam int RIM_B_FULL = 2;
  localparam int RIM_B_NOT_EMPTY = 1;
  localparam int RIM_B_OVERRUN = 0;

  // ----------------------------------------------------------------
  // Field positions, interrupt_config_group offset 0x0E
  // ----------------------------------------------------------------
  localparam int RIM_B_FILL_METHOD = 7;
  localparam int RIM_B_FILL = 6;
  localparam int RIM_B_TX_DONE = 5;
  localparam int RIM_B_TX_START = 4;
  localparam int RIM_B_SL_ENABLE = 3;
  localparam int RIM_B_SL_FLAG = 2;
  localparam int RIM_B_PLL_LOCKED = 1;
  localparam int RIM_B_LOCK_OUT_EN = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] RIM_RST_IRQ_SEL = 2'h0;
  localparam logic RIM_RST_TX_IRQ1 = 1'b0;
  localparam logic RIM_RST_FILL_METHOD = 1'b0;
  localparam logic RIM_RST_TX_START = 1'b0;
  localparam logic RIM_RST_SL_ENABLE = 1'b0;
  localparam logic RIM_RST_LOCK_OUT_EN = 1'b1;
  localparam logic [7:0] RIM_RST_SL_LIMIT = 8'h00;

  // ----------------------------------------------------------------
  // Data modes, FIFO capacity
  // ----------------------------------------------------------------
  localparam logic [1:0] RIM_MODE_CONT = 2'h0;
  localparam logic [1:0] RIM_MODE_BUF = 2'h1;
  localparam logic [6:0] RIM_CAP_STEP = 7'h10;

  typedef enum logic {RIM_ST_RX_STBY, RIM_ST_TX} rim_op_type;

  // Status coming from the modem and FIFO logic on the same clock
  typedef struct packed {
    logic [1:0] data_mode;
    rim_op_type op_state;
    logic sync_det;
    logic adrs_match;
    logic adrs_filt_en;
    logic payload_ready;
    logic crc_ok;
    logic write_byte;
    logic recovered_bit_clock;
    logic overrun_evt;
    logic tx_last_bit;
  } rim_core_type;

  // Derived FIFO levels
  typedef struct packed {
    logic full;
    logic not_empty;
    logic at_level;
  } rim_fifo_type;

  // Capacity for a size code: 16, 32, 48 or 64 bytes
  function automatic logic [6:0] rim_capacity(input logic [1:0] code);
    rim_capacity = 7'(({5'h00, code} + 7'h01) * RIM_CAP_STEP);
  endfunction : rim_capacity

endpackage : rim_pkg

/* File: rim_fifo_level.sv */
`timescale 1ns/1ps
`default_nettype none
module rim_fifo_level
  import rim_pkg::*;
#(
  parameter int COUNT_W = 7
) (
  input wire logic [COUNT_W-1:0] count_i,
  input wire logic [1:0] size_code_i,
  input wire logic [5:0] level_i,
  output rim_fifo_type lvl_o
);

  if (COUNT_W < 7) begin : g_width_check
    $error("rim_fifo_level: COUNT_W must hold a count of 64");
  end

  always_comb begin
    lvl_o.full = (count_i >= COUNT_W'(rim_capacity(size_code_i)));
    lvl_o.not_empty = (count_i != '0);
    lvl_o.at_level = (count_i >= COUNT_W'(level_i));
  end

endmodule : rim_fifo_level
`default_nettype wire

/* File: rim_irq_mux.sv */
`timescale 1ns/1ps
`default_nettype none
module rim_irq_mux
  import rim_pkg::*;
(
  input wire rim_core_type core_i,
  input wire rim_fifo_type lvl_i,
  input wire logic [1:0] rx_sel0_i,
  input wire logic [1:0] rx_sel1_i,
  input wire logic tx_sel1_i,
  input wire logic tx_start_sel_i,
  input wire logic sl_flag_i,
  input wire logic tx_done_i,
  output logic irq0_o,
  output logic irq1_o
);

  logic sync_or_adrs;
  logic packet;

  // Purely combinational so the pins follow any selector or mode change
  always_comb begin
    sync_or_adrs = core_i.adrs_filt_en ? core_i.adrs_match : core_i.sync_det;
    packet = core_i.data_mode[1];
    irq0_o = 1'b0;
    irq1_o = 1'b0;
    if (core_i.op_state == RIM_ST_TX) begin
      if (core_i.data_mode == RIM_MODE_CONT) begin
        irq1_o = core_i.recovered_bit_clock;
      end else begin
        irq1_o = tx_sel1_i ? tx_done_i : lvl_i.full;
        if (packet && !tx_start_sel_i) begin
          irq0_o = lvl_i.at_level;
        end else begin
          irq0_o = lvl_i.not_empty;
        end
      end
    end else if (core_i.data_mode == RIM_MODE_CONT) begin
      irq0_o = (rx_sel0_i == 2'h1) ? sl_flag_i : core_i.sync_det;
      irq1_o = core_i.recovered_bit_clock;
    end else begin
      // FIFO levels do not depend on receive activity, so they serve standby too
      unique case (rx_sel0_i)
        2'h0: irq0_o = packet & core_i.payload_ready;
        2'h1: irq0_o = core_i.write_byte;
        2'h2: irq0_o = lvl_i.not_empty;
        2'h3: irq0_o = packet ? sync_or_adrs : core_i.sync_det;
      endcase
      unique case (rx_sel1_i)
        2'h0: irq1_o = packet & core_i.crc_ok;
        2'h1: irq1_o = lvl_i.full;
        2'h2: irq1_o = sl_flag_i;
        2'h3: irq1_o = lvl_i.at_level;
      endcase
    end
  end

endmodule : rim_irq_mux
`default_nettype wire

/* File: rim_top.sv */
// Functional notes
// - Continuous receive: pin 0 shows sync, or signal-level event for code 01.
// - Buffered/packet receive: pin 0 selects none/payload, byte written, not-empty, sync (address match in packet with address filter).
// - Receive pin 1: bit clock in continuous, else none/CRC, full, level, threshold.
// - FIFO level sources stay selectable in standby as well as receive.
// - Transmit pin 1: bit clock in continuous, else full or transmit done.
// - Read-only full bit high when FIFO holds its configured capacity.
// - Read-only not-empty bit, low only when FIFO holds nothing.
// - Overrun sets sticky flag; writing one clears flag and FIFO.
// - Buffered fill method: automatic on sync, or manual by fill bit.
// - Automatic fill bit high while loading; write one rearms unless overrun pending.
// - Manual fill: host writes fill bit to start or stop loading.
// - Transmit-done bit rises when last bit leaves the shift register.
// - Buffered transmit starts on full or not-empty; pin 0 shows not-empty.
// - Packet transmit starts at threshold or not-empty; pin 0 follows.
// - Enable bit, reset low, gates the signal-level event source.
// - Sticky signal-level flag set above limit; write one clears.
// - Synthesizer lock status bit, write one clears.
// - Lock output enable drives lock on pin, else pin released.
// - Eight-bit signal-level limit, reset zero, compared with measured level.
// - Measured level and limit share the half-decibel per step scale.
// - Full follows capacity code: 16, 32, 48 or 64 bytes.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module rim_top
  import rim_pkg::*;
#(
  parameter int COUNT_W = 7
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Modem and FIFO status
  input wire rim_core_type core_i,
  input wire logic [COUNT_W-1:0] fifo_count_i,
  input wire logic [1:0] fifo_size_i,
  input wire logic [5:0] buffer_level_setting_i,
  input wire logic [7:0] signal_level_i,
  input wire logic pll_lock_i,
  // Pins and controls
  output logic irq0_o,
  output logic irq1_o,
  output logic lock_pin_o,
  output logic lock_pin_oe_o,
  output logic fifo_clear_o,
  output logic fifo_load_en_o,
  output logic tx_start_o
);

  if (COUNT_W < 7) begin : g_width_check
    $error("rim_top: COUNT_W must hold a count of 64");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] rx_sel0_reg;
  logic [1:0] rx_sel1_reg;
  logic tx_sel1_reg;
  logic overrun_reg;
  logic fill_method_reg;
  logic fill_reg;
  logic tx_done_reg;
  logic tx_start_sel_reg;
  logic sl_enable_reg;
  logic sl_flag_reg;
  logic pll_locked_reg;
  logic lock_out_en_reg;
  logic [7:0] sl_limit_reg;
  logic [1:0] lock_sync_reg;
  logic tx_start_reg;
  logic [7:0] rdata_next;
  logic wr_irq_sel;
  logic wr_fill_tx;
  logic wr_limit;
  logic clr_overrun;
  logic rearm_fill;
  logic buffered;
  logic tx_start_next;
  logic irq0_next;
  logic irq1_next;
  rim_fifo_type lvl;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  rim_fifo_level #(
    .COUNT_W(COUNT_W)
  ) u_level (
    .count_i(fifo_count_i),
    .size_code_i(fifo_size_i),
    .level_i(buffer_level_setting_i),
    .lvl_o(lvl)
  );

  rim_irq_mux u_mux (
    .core_i(core_i),
    .lvl_i(lvl),
    .rx_sel0_i(rx_sel0_reg),
    .rx_sel1_i(rx_sel1_reg),
    .tx_sel1_i(tx_sel1_reg),
    .tx_start_sel_i(tx_start_sel_reg),
    .sl_flag_i(sl_flag_reg),
    .tx_done_i(tx_done_reg),
    .irq0_o(irq0_next),
    .irq1_o(irq1_next)
  );

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  assign wr_irq_sel = ce_i & wr_i & (addr_i == RIM_OFS_IRQ_SEL);
  assign wr_fill_tx = ce_i & wr_i & (addr_i == RIM_OFS_FILL_TX);
  assign wr_limit = ce_i & wr_i & (addr_i == RIM_OFS_SL_LIMIT);
  assign clr_overrun = wr_irq_sel & wdata_i[RIM_B_OVERRUN];
  assign buffered = (core_i.data_mode == RIM_MODE_BUF);
  // A pending overrun blocks the rearm until it has been cleared
  assign rearm_fill = wr_fill_tx & wdata_i[RIM_B_FILL] & ~overrun_reg;

  // ----------------------------------------------------------------
  // Lock input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_sync_reg <= 2'h0;
    end else if (ce_i) begin
      lock_sync_reg <= {lock_sync_reg[0], pll_lock_i};
    end
  end

  // ----------------------------------------------------------------
  // Source selectors
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_sel0_reg <= RIM_RST_IRQ_SEL;
      rx_sel1_reg <= RIM_RST_IRQ_SEL;
      tx_sel1_reg <= RIM_RST_TX_IRQ1;
    end else if (wr_irq_sel) begin
      rx_sel0_reg <= wdata_i[RIM_B_RX_IRQ0_HI:RIM_B_RX_IRQ0_LO];
      rx_sel1_reg <= wdata_i[RIM_B_RX_IRQ1_HI:RIM_B_RX_IRQ1_LO];
      tx_sel1_reg <= wdata_i[RIM_B_TX_IRQ1];
    end
  end

  // ----------------------------------------------------------------
  // Overrun flag
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      overrun_reg <= 1'b0;
    end else if (ce_i) begin
      // New overrun in the clearing cycle is kept
      if (core_i.overrun_evt) begin
        overrun_reg <= 1'b1;
      end else if (clr_overrun) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  // FIFO flush pulse that goes with the overrun clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_clear_o <= 1'b0;
    end else if (ce_i) begin
      fifo_clear_o <= clr_overrun;
    end
  end

  // ----------------------------------------------------------------
  // Plain control bits of offset 0x0E
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_method_reg <= RIM_RST_FILL_METHOD;
      tx_start_sel_reg <= RIM_RST_TX_START;
      sl_enable_reg <= RIM_RST_SL_ENABLE;
      lock_out_en_reg <= RIM_RST_LOCK_OUT_EN;
    end else if (wr_fill_tx) begin
      fill_method_reg <= wdata_i[RIM_B_FILL_METHOD];
      tx_start_sel_reg <= wdata_i[RIM_B_TX_START];
      sl_enable_reg <= wdata_i[RIM_B_SL_ENABLE];
      lock_out_en_reg <= wdata_i[RIM_B_LOCK_OUT_EN];
    end
  end

  // ----------------------------------------------------------------
  // Fill status and control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_reg <= 1'b0;
    end else if (ce_i) begin
      // A write that selects manual filling takes its fill bit at once
      if (wr_fill_tx ? wdata_i[RIM_B_FILL_METHOD] : fill_method_reg) begin
        // Manual: the bit is plain host control
        if (wr_fill_tx) begin
          fill_reg <= wdata_i[RIM_B_FILL];
        end
      end else if (buffered && core_i.sync_det) begin
        fill_reg <= 1'b1;
      end else if (rearm_fill) begin
        fill_reg <= 1'b0;
      end
    end
  end

  // Loading is gated only in buffered mode; other modes load freely
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_load_en_o <= 1'b0;
    end else if (ce_i) begin
      fifo_load_en_o <= buffered ? fill_reg : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Transmit start and completion
  // ----------------------------------------------------------------
  always_comb begin
    tx_start_next = 1'b0;
    if (core_i.op_state == RIM_ST_TX) begin
      if (buffered) begin
        tx_start_next = tx_start_sel_reg ? lvl.not_empty : lvl.full;
      end else if (core_i.data_mode[1]) begin
        tx_start_next = tx_start_sel_reg ? lvl.not_empty : lvl.at_level;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_start_reg <= 1'b0;
    end else if (ce_i) begin
      tx_start_reg <= tx_start_next;
    end
  end

  // Done stays until the next transmission starts
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_done_reg <= 1'b0;
    end else if (ce_i) begin
      if (core_i.tx_last_bit) begin
        tx_done_reg <= 1'b1;
      end else if (tx_start_next && !tx_start_reg) begin
        tx_done_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Signal level event and limit
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sl_limit_reg <= RIM_RST_SL_LIMIT;
    end else if (wr_limit) begin
      sl_limit_reg <= wdata_i;
    end
  end

  // Both operands are on the same half-decibel scale, so no conversion
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sl_flag_reg <= 1'b0;
    end else if (ce_i) begin
      if (sl_enable_reg && (signal_level_i > sl_limit_reg)) begin
        sl_flag_reg <= 1'b1;
      end else if (wr_fill_tx && wdata_i[RIM_B_SL_FLAG]) begin
        sl_flag_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Synthesizer lock
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_locked_reg <= 1'b0;
    end else if (ce_i) begin
      // While still locked a clear is overridden on the same edge
      if (lock_sync_reg[1]) begin
        pll_locked_reg <= 1'b1;
      end else if (wr_fill_tx && wdata_i[RIM_B_PLL_LOCKED]) begin
        pll_locked_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lock_pin_o <= 1'b0;
      lock_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      lock_pin_o <= pll_locked_reg & lock_out_en_reg;
      lock_pin_oe_o <= lock_out_en_reg;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pins and transmit start output
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq0_o <= 1'b0;
      irq1_o <= 1'b0;
      tx_start_o <= 1'b0;
    end else if (ce_i) begin
      irq0_o <= irq0_next;
      irq1_o <= irq1_next;
      tx_start_o <= tx_start_next;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    unique case (addr_i)
      RIM_OFS_IRQ_SEL: begin
        rdata_next[RIM_B_RX_IRQ0_HI:RIM_B_RX_IRQ0_LO] = rx_sel0_reg;
        rdata_next[RIM_B_RX_IRQ1_HI:RIM_B_RX_IRQ1_LO] = rx_sel1_reg;
        rdata_next[RIM_B_TX_IRQ1] = tx_sel1_reg;
        rdata_next[RIM_B_FULL] = lvl.full;
        rdata_next[RIM_B_NOT_EMPTY] = lvl.not_empty;
        rdata_next[RIM_B_OVERRUN] = overrun_reg;
      end
      RIM_OFS_FILL_TX: begin
        rdata_next[RIM_B_FILL_METHOD] = fill_method_reg;
        rdata_next[RIM_B_FILL] = fill_reg;
        rdata_next[RIM_B_TX_DONE] = tx_done_reg;
        rdata_next[RIM_B_TX_START] = tx_start_sel_reg;
        rdata_next[RIM_B_SL_ENABLE] = sl_enable_reg;
        rdata_next[RIM_B_SL_FLAG] = sl_flag_reg;
        rdata_next[RIM_B_PLL_LOCKED] = pll_locked_reg;
        rdata_next[RIM_B_LOCK_OUT_EN] = lock_out_en_reg;
      end
      RIM_OFS_SL_LIMIT: rdata_next = sl_limit_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // Data held otherwise at zero so it stands only in the cycle after a read
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rdata_next : 8'h00;
    end
  end

endmodule : rim_top
`default_nettype wire

/* File: rim_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module rim_checker
  import rim_pkg::*;
#(
  parameter int COUNT_W = 7
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire rim_core_type core_i,
  input wire logic [COUNT_W-1:0] fifo_count_i,
  input wire logic [5:0] buffer_level_setting_i,
  input wire logic irq1_o,
  input wire logic fifo_clear_o,
  input wire logic fifo_load_en_o,
  input wire logic tx_start_o
);
  logic bit_clk;
  logic is_tx;
  logic is_cont;
  logic is_buf;
  logic no_data;
  assign bit_clk = core_i.recovered_bit_clock;
  assign is_tx = core_i.op_state == RIM_ST_TX;
  assign is_cont = core_i.data_mode == RIM_MODE_CONT;
  assign is_buf = core_i.data_mode == RIM_MODE_BUF;
  assign no_data = fifo_count_i == '0;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------
  // Pins, clears and start conditions
  // ----------------------------------------------------------------
  a_rx_pin_clock: assert property (ce_i && is_cont && !is_tx |=> irq1_o == $past(bit_clk))
    else $error("pin 1 misses bit clock in receive");
  a_tx_pin_clock: assert property (ce_i && is_cont && is_tx |=> irq1_o ~^ $past(bit_clk))
    else $error("pin 1 misses bit clock in transmit");
  a_clear_on_write: assert property (ce_i && wr_i && addr_i == RIM_OFS_IRQ_SEL
      && wdata_i[RIM_B_OVERRUN] |=> fifo_clear_o)
    else $error("overrun clear gave no flush pulse");
  a_clear_cause: assert property (fifo_clear_o |-> $past(wr_i)
      && $past(addr_i) == RIM_OFS_IRQ_SEL && $past(wdata_i[RIM_B_OVERRUN]))
    else $error("flush pulse without a clear write");
  a_load_other_modes: assert property (ce_i && !is_buf |=> fifo_load_en_o)
    else $error("loading off outside buffered mode");
  a_start_only_tx: assert property (ce_i && (!is_tx || is_cont) |=> !tx_start_o)
    else $error("start outside buffered or packet transmit");
  a_buf_empty_idle: assert property ((ce_i && is_tx && is_buf && no_data) [*2] |=> !tx_start_o)
    else $error("buffered start with empty storage");
  a_pkt_below_level: assert property (ce_i && is_tx && core_i.data_mode[1] && no_data
      && buffer_level_setting_i != 6'h00 |=> !tx_start_o)
    else $error("packet start below threshold");
endmodule : rim_checker

bind rim_top rim_checker #(.COUNT_W(COUNT_W)) chk_u (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .core_i(core_i), .fifo_count_i(fifo_count_i),
  .buffer_level_setting_i(buffer_level_setting_i), .irq1_o(irq1_o),
  .fifo_clear_o(fifo_clear_o), .fifo_load_en_o(fifo_load_en_o), .tx_start_o(tx_start_o)
);
`default_nettype wire

/* File: rim_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rim_host_model (
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic level_o
);
  // ----------------------------------------------------------------
  // Lock pin as the host sees it
  // ----------------------------------------------------------------
  logic last_reg = 1'b0;
  always_ff @(posedge clk_i) begin
    if (pin_oe_i) begin
      last_reg <= pin_i;
    end
  end
  // No pull on this pin: a released line shows the inverse of the last
  // driven level so a stale value cannot pass for a live one
  assign level_o = pin_oe_i ? pin_i : ~last_reg;
endmodule : rim_host_model
`default_nettype wire

/* File: rim_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rim_bench;
  import rim_pkg::*;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pll = 1'b0, rd_q = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, sig = 8'h00, rdata;
  logic [6:0] cnt = 7'h00, n;
  logic [1:0] fsz = 2'h0, f;
  logic [5:0] lvl = 6'h00, l;
  logic [31:0] r;
  rim_core_type core = '0, c = '0;
  logic irq0, irq1, lpin, loe, fclr, lden, txs, lock_seen;
  logic [7:0] exp_q[$];
  int n_fail = 0, cmp_count = 0, cyc = 0, seed = 32'h08254F05;

  rim_top dut_u (.core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .core_i(core), .fifo_count_i(cnt),
    .fifo_size_i(fsz), .buffer_level_setting_i(lvl), .signal_level_i(sig), .pll_lock_i(pll),
    .irq0_o(irq0), .irq1_o(irq1), .lock_pin_o(lpin), .lock_pin_oe_o(loe),
    .fifo_clear_o(fclr), .fifo_load_en_o(lden), .tx_start_o(txs));
  rim_host_model host_u (.clk_i(clk), .pin_i(lpin), .pin_oe_i(loe), .level_o(lock_seen));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Reporting and register access
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] e);
    cmp_count++;
    if (seen !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, seen);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) rd_q <= rd;
  always @(negedge clk) begin
    if (rd_q) begin
      check("rdata", rdata, exp_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      print_verdict();
    end
  end

  // Expected {tx start, pin 1, pin 0} for selector bits s
  function automatic logic [2:0] exp_pins(input logic [3:0] s, input logic tx);
    logic ne, fu, al, pk, ct;
    logic [3:0] v0, v1;
    ne = n != 7'h00;
    fu = n == ({f, 4'h0} + 7'h10);
    al = n >= {1'b0, l};
    pk = c.data_mode[1];
    ct = c.data_mode == RIM_MODE_CONT;
    v0 = {pk & c.adrs_filt_en ? c.adrs_match : c.sync_det, ne, c.write_byte, pk & c.payload_ready};
    v1 = {al, 1'b0, fu, pk & c.crc_ok};
    if (tx) begin
      return {~ct & (s[0] ? ne : pk ? al : fu), ct ? c.recovered_bit_clock : ~s[1] & fu,
        ~ct & (s[0] | ~pk ? ne : al)};
    end
    return {1'b0, ct ? c.recovered_bit_clock : v1[s[1:0]],
      ct ? (s[3:2] == 2'h1 ? 1'b0 : c.sync_det) : v0[s[3:2]]};
  endfunction : exp_pins

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_reg(RIM_OFS_IRQ_SEL, 8'h00);
    rd_reg(RIM_OFS_FILL_TX, 8'h01);
    rd_reg(RIM_OFS_SL_LIMIT, 8'h00);
    wr_reg(8'h10, 8'hFF);
    rd_reg(8'h10, 8'h00);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      cnt <= 7'(8 * k + 15 + (k % 2));
      fsz <= 2'(k / 2);
      rd_reg(RIM_OFS_IRQ_SEL, {5'h00, k[0], 2'h2});
    end
    for (int op = 0; op < 2; op++) begin
      for (int m = 0; m < 48; m++) begin
        wr_reg(RIM_OFS_IRQ_SEL, {4'(m), m[1], 3'h0});
        wr_reg(RIM_OFS_FILL_TX, {3'h0, m[0], 4'h9});
        r = $random(seed);
        c = r[$bits(c)-1:0];
        c.data_mode = m > 31 ? {1'b1, r[31]} : 2'(m / 16);
        c.op_state = rim_op_type'(op[0]);
        c.overrun_evt = 1'b0;
        c.tx_last_bit = 1'b0;
        {f, l} = r[30:23];
        n = 7'($unsigned($random(seed)) % ({f, 4'h0} + 7'h11));
        n = m[3:2] == 2'h0 ? 7'h00 : m[3:2] == 2'h3 ? {f, 4'h0} + 7'h10 : n;
        @(posedge clk);
        core <= c;
        cnt <= n;
        fsz <= f;
        lvl <= l;
        @(posedge clk);
        @(negedge clk);
        check("pins", {5'h00, txs, irq1, irq0}, {5'h00, exp_pins(4'(m), op[0])});
      end
    end
    c = '0;
    @(posedge clk);
    core <= c;
    cnt <= 7'h00;
    wr_reg(RIM_OFS_SL_LIMIT, 8'h40);
    rd_reg(RIM_OFS_SL_LIMIT, 8'h40);
    wr_reg(RIM_OFS_IRQ_SEL, 8'h40);
    wr_reg(RIM_OFS_FILL_TX, 8'h45);
    sig <= 8'h41;
    rd_reg(RIM_OFS_FILL_TX, 8'h01);
    wr_reg(RIM_OFS_FILL_TX, 8'h09);
    rd_reg(RIM_OFS_FILL_TX, 8'h0D);
    // The pin follows the flag one edge later, so look after it settles
    @(negedge clk);
    check("irq0", {7'h00, irq0}, 8'h01);
    sig <= 8'h40;
    wr_reg(RIM_OFS_FILL_TX, 8'h0D);
    rd_reg(RIM_OFS_FILL_TX, 8'h09);
    c.data_mode = RIM_MODE_BUF;
    c.overrun_evt = 1'b1;
    c.sync_det = 1'b1;
    @(posedge clk);
    core <= c;
    c.overrun_evt = 1'b0;
    c.sync_det = 1'b0;
    @(posedge clk);
    core <= c;
    rd_reg(RIM_OFS_IRQ_SEL, 8'h41);
    wr_reg(RIM_OFS_FILL_TX, 8'h49);
    rd_reg(RIM_OFS_FILL_TX, 8'h49);
    check("load_en", {7'h00, lden}, 8'h01);
    wr_reg(RIM_OFS_IRQ_SEL, 8'h01);
    rd_reg(RIM_OFS_IRQ_SEL, 8'h00);
    wr_reg(RIM_OFS_FILL_TX, 8'h49);
    rd_reg(RIM_OFS_FILL_TX, 8'h09);
    check("load_en", {7'h00, lden}, 8'h00);
    wr_reg(RIM_OFS_FILL_TX, 8'hC9);
    rd_reg(RIM_OFS_FILL_TX, 8'hC9);
    check("load_en", {7'h00, lden}, 8'h01);
    wr_reg(RIM_OFS_FILL_TX, 8'h89);
    pll <= 1'b1;
    rd_reg(RIM_OFS_FILL_TX, 8'h89);
    check("load_en", {7'h00, lden}, 8'h00);
    repeat (2) @(posedge clk);
    rd_reg(RIM_OFS_FILL_TX, 8'h8B);
    check("lock_pin", {7'h00, lock_seen}, 8'h01);
    pll <= 1'b0;
    repeat (3) @(posedge clk);
    wr_reg(RIM_OFS_FILL_TX, 8'h8A);
    rd_reg(RIM_OFS_FILL_TX, 8'h88);
    check("lock_oe", {7'h00, loe}, 8'h00);
    wr_reg(RIM_OFS_IRQ_SEL, 8'h08);
    c.op_state = RIM_ST_TX;
    c.tx_last_bit = 1'b1;
    @(posedge clk);
    core <= c;
    c.tx_last_bit = 1'b0;
    @(posedge clk);
    core <= c;
    rd_reg(RIM_OFS_FILL_TX, 8'hA8);
    check("irq1", {7'h00, irq1}, 8'h01);
    print_verdict();
  end
endmodule : rim_bench
`default_nettype wire
